/* rtl/dual_dac_channel_control.v */
// two-channel converter control: register port, triggers, waves, dma
// assumes a single 40 MHz clock, synchronous triggers, word accesses only
// Notes on behaviour
// - control register resets to all zeros
// - bits 0 and 16 enable each channel
// - bits 1 and 17 turn buffer off
// - bits 2 and 18 make transfers await trigger
// - source field ignored without trigger enable
// - codes select timers, external line, software
// - mode 00 none, 01 noise, 1x triangle
// - wave applies only with trigger enabled
// - width is field plus one, capped twelve
// - noise is low n shifter bits
// - triangle peaks at (2<<(n-1))-1
// - bits 12 and 28 enable dma requests
// - output is holding value plus wave
// - hardware triggers act on rising edge
// - no trigger means automatic copy to output
// - dma request only on hardware trigger
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`include "dac_ctl_consts.vh"

module dual_dac_channel_control (
    input wire ref_clk_in,
    input wire rst_n_in,
    input wire clk_en_in,
    input wire [7:0] addr_in,
    input wire [31:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    output reg [31:0] rdata_out,
    input wire [5:0] timer_trigger_output_in,
    input wire ext_line_in,
    output wire [1:0] chan_on_out,
    output wire [1:0] buffer_off_out,
    output wire [1:0] dma_req_out,
    output wire [1:0] update_out,
    output wire [11:0] chan0_output_value_out,
    output wire [11:0] chan1_output_value_out
);

    // ======================================================
    // registers
    reg [31:0] ctl_q; // converter_channel_control
    // per-channel registers live in the loop; these collect them
    wire [1:0] soft_w;
    wire [1:0] dma_w;
    wire [1:0] upd_w;
    wire [23:0] hold_w;
    wire [23:0] outv_w;
    wire wr_ctl;
    wire wr_soft;
    wire [1:0] hw_ev;
    wire [1:0] sw_ev;

    assign wr_ctl = wr_in && (addr_in == `CTL_OFS);
    assign wr_soft = wr_in && (addr_in == `SWTRIG_OFS);

    // ======================================================
    // control register; reserved bits stay zero on write
    always @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            ctl_q <= `CTL_RESET;
        else if (clk_en_in && wr_ctl)
            ctl_q <= wdata_in & `CTL_WMASK;
    end

    // ======================================================
    // per-channel datapath
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1)
        begin : chan
            wire [15:0] f;
            wire trig_on;
            wire [2:0] src;
            wire [1:0] mode;
            wire [3:0] width;
            wire step;
            wire [11:0] wave;
            wire [12:0] sum;
            wire wr_hold;
            // each channel owns its registers, so no vector has two writers
            reg soft_q; // software trigger, cleared by hardware
            reg [11:0] hold_q; // channel_holding_value
            reg [11:0] outv_q; // channel_output_value
            reg dma_q;
            reg upd_q;

            assign f = ctl_q[`CH1_BASE*g +: 16];
            assign trig_on = f[`F_TRIG];
            // source zeroed unless trigger enabled
            assign src = trig_on ? f[`F_SRC +: 3] : 3'h0;
            // wave forced off without the trigger
            assign mode = trig_on ? f[`F_MODE +: 2] : `MODE_NONE;
            assign width = (f[`F_WIDTH +: 4] > `WIDTH_MAX) ?
                           `WIDTH_MAX : f[`F_WIDTH +: 4];
            assign wr_hold = wr_in && (addr_in ==
                             (g == 0 ? `HOLD0_OFS : `HOLD1_OFS));

            edge_pick u_pick (
                .ref_clk_in(ref_clk_in),
                .rst_n_in(rst_n_in),
                .clk_en_in(clk_en_in),
                .src_in(src),
                .timer_trigger_output_in(timer_trigger_output_in),
                .ext_line_in(ext_line_in),
                .soft_in(soft_q),
                .hw_event_out(hw_ev[g]),
                .soft_event_out(sw_ev[g])
            );

            assign step = trig_on && f[`F_ON] && (hw_ev[g] || sw_ev[g]);

            wave_source u_wave (
                .ref_clk_in(ref_clk_in),
                .rst_n_in(rst_n_in),
                .clk_en_in(clk_en_in),
                .step_in(step),
                .mode_in(mode),
                .width_in(width),
                .wave_out(wave)
            );

            assign sum = {1'b0, hold_q} + {1'b0, wave};

            // holding, output, software trigger, dma and update pulse
            always @(posedge ref_clk_in or negedge rst_n_in)
            begin
                if (!rst_n_in)
                begin
                    hold_q <= 12'h000;
                    outv_q <= 12'h000;
                    soft_q <= 1'b0;
                    dma_q <= 1'b0;
                    upd_q <= 1'b0;
                end
                else if (clk_en_in)
                begin
                    if (wr_hold)
                        hold_q <= wdata_in[11:0];
                    // a new write beats the hardware clear
                    if (wr_soft && wdata_in[g])
                        soft_q <= 1'b1;
                    else if (sw_ev[g] || !trig_on)
                        soft_q <= 1'b0;
                    upd_q <= 1'b0;
                    // only an enabled channel converts
                    if (f[`F_ON])
                    begin
                        if (!trig_on)
                        begin
                            outv_q <= hold_q;
                            upd_q <= 1'b1;
                        end
                        else if (step)
                        begin
                            outv_q <= sum[11:0];
                            upd_q <= 1'b1;
                        end
                    end
                    // request only on hardware edges
                    dma_q <= f[`F_DMA] && trig_on && f[`F_ON] &&
                             hw_ev[g];
                end
            end

            // per-channel taps onto the shared vectors, one writer per bit
            assign soft_w[g] = soft_q;
            assign dma_w[g] = dma_q;
            assign upd_w[g] = upd_q;
            assign hold_w[12*g +: 12] = hold_q;
            assign outv_w[12*g +: 12] = outv_q;

            assign chan_on_out[g] = f[`F_ON];
            assign buffer_off_out[g] = f[`F_BUFOFF];
        end
    endgenerate

    assign dma_req_out = dma_w;
    assign update_out = upd_w;
    assign chan0_output_value_out = outv_w[11:0];
    assign chan1_output_value_out = outv_w[23:12];

    // ======================================================
    // read port: data in the cycle after the strobe; unmapped read zero
    always @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            rdata_out <= 32'h0000_0000;
        else if (clk_en_in)
        begin
            if (rd_in)
            begin
                case (addr_in)
                    `CTL_OFS: rdata_out <= ctl_q;
                    `SWTRIG_OFS: rdata_out <= {30'h0, soft_w};
                    `HOLD0_OFS: rdata_out <= {20'h0, hold_w[11:0]};
                    `HOLD1_OFS: rdata_out <= {20'h0, hold_w[23:12]};
                    `OUTV0_OFS: rdata_out <= {20'h0, outv_w[11:0]};
                    `OUTV1_OFS: rdata_out <= {20'h0, outv_w[23:12]};
                    default: rdata_out <= 32'h0000_0000;
                endcase
            end
            else
                rdata_out <= 32'h0000_0000;
        end
    end
endmodule

/* rtl/dac_ctl_consts.vh */
// constants for the dual converter channel control block
// assumes inclusion by bare name from rtl/ design files
`ifndef DAC_CTL_CONSTS_VH
`define DAC_CTL_CONSTS_VH

// ==========================================================
// register offsets (byte addresses, word registers)
`define CTL_OFS 8'h00
`define SWTRIG_OFS 8'h04
`define HOLD0_OFS 8'h08
`define HOLD1_OFS 8'h0c
`define OUTV0_OFS 8'h10
`define OUTV1_OFS 8'h14

// ==========================================================
// control register reset value and layout
`define CTL_RESET 32'h0000_0000
`define CTL_WMASK 32'h1fff_1fff
`define CH1_BASE 16
`define F_ON 0
`define F_BUFOFF 1
`define F_TRIG 2
`define F_SRC 3
`define F_MODE 6
`define F_WIDTH 8
`define F_DMA 12

// ==========================================================
// trigger source codes and wave modes
`define SRC_EXT_LINE 3'h6
`define SRC_SOFT 3'h7
`define MODE_NONE 2'h0
`define MODE_NOISE 2'h1
`define WIDTH_MAX 4'hb
`define SHIFTER_SEED 12'haaa
`define DATA_W 12

`endif

/* rtl/wave_source.v */
// one channel's noise or triangle wave generator
// assumes step_in pulses once per conversion event, width already clipped
`timescale 1ns/1ps
`include "dac_ctl_consts.vh"

module wave_source (
    input wire ref_clk_in,
    input wire rst_n_in,
    input wire clk_en_in,
    input wire step_in,
    input wire [1:0] mode_in,
    input wire [3:0] width_in,
    output wire [11:0] wave_out
);

    // ======================================================
    // state
    reg [11:0] shifter_q;
    reg [11:0] tri_q;
    reg tri_down_q;
    wire [11:0] mask;
    wire [11:0] peak;
    wire fb;

    // mask of n low bits; also the triangle peak (2<<(n-1))-1
    assign mask = {12{1'b1}} >> (4'hb - width_in);
    assign peak = mask;
    // taps of a 12-bit maximal sequence
    assign fb = shifter_q[11] ^ shifter_q[5] ^ shifter_q[3] ^ shifter_q[0];

    // ======================================================
    // shifter and triangle counter advance only on a conversion
    always @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            shifter_q <= `SHIFTER_SEED;
            tri_q <= 12'h000;
            tri_down_q <= 1'b0;
        end
        else if (clk_en_in && step_in)
        begin
            shifter_q <= {shifter_q[10:0], fb};
            // narrowing the width mid-ramp restarts from zero
            if (tri_q > peak)
            begin
                tri_q <= 12'h000;
                tri_down_q <= 1'b0;
            end
            else if (!tri_down_q)
            begin
                if (tri_q == peak)
                begin
                    tri_down_q <= 1'b1;
                    tri_q <= tri_q - 12'h001;
                end
                else
                    tri_q <= tri_q + 12'h001;
            end
            else
            begin
                if (tri_q == 12'h000)
                begin
                    tri_down_q <= 1'b0;
                    tri_q <= 12'h001;
                end
                else
                    tri_q <= tri_q - 12'h001;
            end
        end
    end

    // noise keeps only low n bits; mode 1x is triangle
    assign wave_out = (mode_in == `MODE_NONE) ? 12'h000 :
                      (mode_in == `MODE_NOISE) ? (shifter_q & mask) :
                      (tri_q & mask);
endmodule

/* rtl/edge_pick.v */
// trigger source selector with synchronous rising edge detection
// assumes trigger inputs are synchronous to ref_clk_in
`timescale 1ns/1ps
`include "dac_ctl_consts.vh"

module edge_pick (
    input wire ref_clk_in,
    input wire rst_n_in,
    input wire clk_en_in,
    input wire [2:0] src_in,
    input wire [5:0] timer_trigger_output_in,
    input wire ext_line_in,
    input wire soft_in,
    output wire hw_event_out,
    output wire soft_event_out
);

    reg [6:0] prev_q;
    wire [6:0] lines;

    assign lines = {ext_line_in, timer_trigger_output_in};

    // ======================================================
    // previous levels for edge detection
    always @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            prev_q <= 7'h00;
        else if (clk_en_in)
            prev_q <= lines;
    end

    // codes 0..5 timers, 6 external line, 7 software
    assign hw_event_out = (src_in != `SRC_SOFT) &&
                          lines[src_in] && !prev_q[src_in];
    assign soft_event_out = (src_in == `SRC_SOFT) && soft_in;
endmodule

/* dv/trig_source_model.sv */
// timer and external trigger line source facing the converter block
// assumes fire_in is a one-cycle request driven just after a clock edge
`timescale 1ns/1ps

module trig_source_model (
    input wire ref_clk_in,
    input wire fire_in,
    input wire [2:0] sel_in,
    output logic [5:0] timer_trigger_output_out,
    output logic ext_line_out
);
    logic [1:0] left_q;
    // ==========================================================
    // line pulse
    // lines stay up two cycles, then drop, so each firing is a fresh edge
    initial
    begin
        left_q = 2'h0;
        timer_trigger_output_out = 6'h00;
        ext_line_out = 1'b0;
    end
    always @(posedge ref_clk_in)
    begin
        if (fire_in)
        begin
            left_q <= 2'h2;
            timer_trigger_output_out <= 6'h01 << sel_in;
            ext_line_out <= (sel_in == 3'h6);
        end
        else
        begin
            left_q <= left_q >> 1;
            if (left_q == 2'h1)
            begin
                timer_trigger_output_out <= 6'h00;
                ext_line_out <= 1'b0;
            end
        end
    end
endmodule

/* dv/dac_ctl_chk_props.sv */
// port checker for the dual converter channel control block
// assumes one clock domain; bound onto the design top below
`timescale 1ns/1ps

module dac_ctl_chk (
    input wire ref_clk_in,
    input wire rst_n_in,
    input wire clk_en_in,
    input wire [7:0] addr_in,
    input wire [31:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    input wire [31:0] rdata_out,
    input wire [5:0] timer_trigger_output_in,
    input wire ext_line_in,
    input wire [1:0] chan_on_out,
    input wire [1:0] buffer_off_out,
    input wire [1:0] dma_req_out,
    input wire [1:0] update_out,
    input wire [11:0] chan0_output_value_out,
    input wire [11:0] chan1_output_value_out
);
    // ==========================================================
    // control register accesses
    wire ctl_wr = wr_in && clk_en_in && addr_in == 8'h00;
    wire ctl_rd = rd_in && clk_en_in && addr_in == 8'h00;
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    AST_RST_QUIET: assert property (disable iff (1'b0)
        !rst_n_in |-> chan_on_out == 2'h0 && rdata_out == 32'h0)
        else $error("outputs active in reset");
    AST_WR_ON: assert property (ctl_wr |=>
        chan_on_out == {$past(wdata_in[16]), $past(wdata_in[0])})
        else $error("enable bits not taken");
    AST_WR_BUF: assert property (ctl_wr |=>
        buffer_off_out == {$past(wdata_in[17]), $past(wdata_in[1])})
        else $error("buffer bits not taken");
    AST_RSV_ZERO: assert property (ctl_rd |=>
        rdata_out[31:29] == 3'h0 && rdata_out[15:13] == 3'h0)
        else $error("reserved bits read back");
    AST_RD_MATCH: assert property (ctl_rd |=>
        {rdata_out[17:16], rdata_out[1:0]} == {buffer_off_out[1],
        chan_on_out[1], buffer_off_out[0], chan_on_out[0]})
        else $error("read data differs from controls");
    // a frozen cycle keeps the last read data, so only enabled slots count
    AST_RD_IDLE: assert property ($past(clk_en_in) && !$past(rd_in) |->
        rdata_out == 32'h0)
        else $error("read data outside read slot");
    AST_OUT_HOLD: assert property (!update_out[0] |->
        $stable(chan0_output_value_out))
        else $error("output moved without update");
    AST_DMA_UPD: assert property (dma_req_out[0] |->
        update_out[0] && $past(chan_on_out[0]))
        else $error("dma without conversion");
    AST_DMA_GAP: assert property (dma_req_out[0] |=> !dma_req_out[0])
        else $error("dma request not a pulse");
    cover property (ctl_wr);
    cover property (dma_req_out[0]);
    cover property (update_out[0] && chan0_output_value_out == 12'h000);
endmodule

bind dual_dac_channel_control dac_ctl_chk i_chk (.ref_clk_in, .rst_n_in,
    .clk_en_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .timer_trigger_output_in, .ext_line_in, .chan_on_out, .buffer_off_out,
    .dma_req_out, .update_out, .chan0_output_value_out,
    .chan1_output_value_out);

/* dv/tb.sv */
// self-checking bench for the dual converter channel control block
// assumes the rtl/ headers on the include path and the trigger model
`timescale 1ns/1ps
`include "dac_ctl_consts.vh"

module tb;
    logic ref_clk_in;
    logic rst_n_in;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic fire;
    logic [2:0] sel;
    wire [31:0] rdata;
    wire [5:0] tmr;
    wire ext;
    wire [1:0] on_w, boff_w, dma_w, upd_w;
    wire [11:0] out0, out1;
    int err_total;
    int compares;
    logic [31:0] d;
    logic [11:0] v;
    logic [11:0] f;
    logic dm;
    logic en;
    logic ch;
    // ==========================================================
    // design and trigger source; clock enable driven by the bench
    dual_dac_channel_control i_dut (.ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in), .clk_en_in(en), .addr_in(addr),
        .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
        .timer_trigger_output_in(tmr), .ext_line_in(ext),
        .chan_on_out(on_w), .buffer_off_out(boff_w), .dma_req_out(dma_w),
        .update_out(upd_w), .chan0_output_value_out(out0),
        .chan1_output_value_out(out1));
    trig_source_model i_src (.ref_clk_in(ref_clk_in), .fire_in(fire),
        .sel_in(sel), .timer_trigger_output_out(tmr), .ext_line_out(ext));
    // ==========================================================
    // helpers
    initial
    begin
        ref_clk_in = 1'b0;
        forever #12.5 ref_clk_in = ~ref_clk_in;
    end
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task wr_reg(input logic [7:0] a, input logic [31:0] x);
        addr <= a;
        wdata <= x;
        wr <= 1'b1;
        @(posedge ref_clk_in);
        wr <= 1'b0;
        // one idle edge, so a following call never re-raises wr at once
        @(posedge ref_clk_in);
    endtask
    task rd_reg(input logic [7:0] a);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk_in);
        rd <= 1'b0;
        @(negedge ref_clk_in);
        d = rdata;
        @(posedge ref_clk_in);
    endtask
    // fire one source, then wait boundedly for the update of channel ch
    task pulse(input logic [2:0] s);
        int n;
        n = 0;
        if (s == 3'h7)
            wr_reg(`SWTRIG_OFS, 32'h1 << ch);
        else
        begin
            fire <= 1'b1;
            sel <= s;
            @(posedge ref_clk_in);
            fire <= 1'b0;
        end
        @(negedge ref_clk_in);
        while (upd_w[ch] !== 1'b1 && n < 20)
        begin
            @(negedge ref_clk_in);
            n++;
        end
        chk("update", 1, upd_w[ch]);
        v = ch ? out1 : out0;
        dm = dma_w[ch];
        @(posedge ref_clk_in);
    endtask
    task set_ctl(input logic [11:0] h, input logic [31:0] c);
        wr_reg(`HOLD0_OFS, {20'h0, h});
        wr_reg(`CTL_OFS, c);
        @(posedge ref_clk_in);
    endtask
    // ==========================================================
    // scenarios
    task t_regs;
        rd_reg(`CTL_OFS);
        chk("ctl_reset", 32'h0, d);
        rd_reg(8'h40);
        chk("unmapped", 32'h0, d);
        wr_reg(`CTL_OFS, 32'hffff_ffff);
        rd_reg(`CTL_OFS);
        chk("ctl_rsv", 32'h1fff_1fff, d);
        chk("chan_on", 32'h3, {30'h0, on_w});
        chk("buf_off", 32'h3, {30'h0, boff_w});
    endtask
    task t_auto;
        set_ctl(12'h123, 32'h0000_1141);
        pulse(3'h0);
        chk("auto_out", 32'h123, {20'h0, v});
        chk("auto_dma", 32'h0, {31'h0, dm});
    endtask
    task t_hw;
        for (int k = 0; k < 7; k++)
        begin
            set_ctl(12'(12'h200 + k), 32'h1005 | (k << 3));
            pulse(k[2:0]);
            chk("hw_out", 32'h200 + k, {20'h0, v});
            chk("hw_dma", 32'h1, {31'h0, dm});
        end
    endtask
    task t_soft;
        set_ctl(12'h321, 32'h0000_103d);
        pulse(3'h7);
        chk("sw_out", 32'h321, {20'h0, v});
        chk("sw_dma", 32'h0, {31'h0, dm});
    endtask
    // width code 0 gives a peak of 1, so the sum wraps at the top
    task t_tri;
        set_ctl(12'hfff, 32'h0000_00bd);
        pulse(3'h7);
        f = v;
        pulse(3'h7);
        chk("tri_b", {20'h0, f ^ 12'hfff}, {20'h0, v});
        pulse(3'h7);
        chk("tri_c", {20'h0, f}, {20'h0, v});
    endtask
    task t_noise;
        for (int w = 0; w < 11; w++)
        begin
            set_ctl(12'h000, 32'h007d | (w << 8));
            pulse(3'h7);
            chk("noise_hi", 32'h0, {20'h0, v} >> (w + 1));
        end
    endtask
    // channel 1 alone: timer edge with dma, then software trigger
    task t_ch1;
        ch = 1'b1;
        wr_reg(`HOLD1_OFS, 32'h0000_0456);
        wr_reg(`CTL_OFS, 32'h102d_0000);
        pulse(3'h5);
        chk("c1_out", 32'h456, {20'h0, v});
        chk("c1_dma", 32'h1, {31'h0, dm});
        chk("c0_off", 32'h0, {31'h0, upd_w[0]});
        wr_reg(`CTL_OFS, 32'h103d_0000);
        pulse(3'h7);
        chk("c1_sw_out", 32'h456, {20'h0, v});
        chk("c1_sw_dma", 32'h0, {31'h0, dm});
        ch = 1'b0;
    endtask
    // clock enable low: a write in that cycle must leave no trace
    task t_freeze;
        en <= 1'b0;
        wr_reg(`HOLD0_OFS, 32'h0000_0777);
        en <= 1'b1;
        rd_reg(`HOLD0_OFS);
        chk("frozen_hold", 32'h0, d);
    endtask
    // ==========================================================
    // run control
    task print_verdict;
        $display("errors %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        repeat (5000) @(posedge ref_clk_in);
        err_total++;
        print_verdict;
    end
    initial
    begin
        {addr, wdata, wr, rd, fire, sel} = '0;
        en = 1'b1;
        ch = 1'b0;
        rst_n_in = 1'b0;
        err_total = 0;
        compares = 0;
        repeat (20) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        @(posedge ref_clk_in);
        t_regs;
        t_auto;
        t_hw;
        t_soft;
        t_tri;
        t_noise;
        t_ch1;
        t_freeze;
        print_verdict;
    end
endmodule
